// ---- mstu_top.sv ----
/*
 * mstu_top: multiply / multiply-accumulate and status word transfer
 * execution unit, with an ahb-lite register slave.
 * assumes: decoder presents one instruction with register values already
 * read; it issues only while issue_ready is high; single hclk domain.
 */
//
// Overview of operation
// RQ1 - status transfers retire one cycle after issue
// RQ2 - flags write copies source 31:28 to nzcv
// RQ3 - immediate flags write uses rotated 32-bit value
// RQ4 - user mode whole write changes flags only
// RQ5 - privileged whole write loads all 32 bits
// RQ6 - status read returns all 32 bits
// RQ7 - failed condition changes nothing
// RQ8 - booth array retires eight bits per iteration
// RQ9 - plain multiply ignores addend
// RQ10 - accumulate adds addend to product
// RQ11 - only low 32 product bits kept
// RQ12 - software avoids dest equal first source, pc
// RQ13 - operand values latched, so register aliasing safe
// RQ14 - n gets bit 31, z when result zero
// RQ15 - carry arbitrary, overflow kept on multiply
// RQ16 - multiply m cycles, accumulate one more
// RQ17 - software zeroes unused addend field
// RQ18 - multiply encoding fields as laid out
// RQ19 - one to four iterations, early stop
`timescale 1ns/1ps

module mstu_top (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// instruction issue from decoder
	input wire mstu_pkg::mstu_issue_t issue,
	output logic issue_ready,
	// register file write back
	output mstu_pkg::mstu_wb_t wb,
	output logic retire,
	// status words
	output logic [31:0] current_status_word,
	output logic [31:0] saved_status_word
);

	typedef struct packed {
		mstu_pkg::mstu_fsm_t fsm;
		logic [31:0] acc;
		logic [31:0] mcand;
		logic [31:0] mplier;
		logic prev;
		logic [2:0] iter_left;
		logic [2:0] last_m;
		logic [31:0] addend;
		logic accum;
		logic setf;
		logic [3:0] dest;
		logic [31:0] cur;
		logic [31:0] sav;
		mstu_pkg::mstu_wb_t wb;
		logic retire;
		logic ready;
		logic [31:0] ctl;
		logic ahb_wr;
		logic [3:0] ahb_addr;
		logic [31:0] hrdata;
		logic hreadyout;
	} mstu_state_t;

	mstu_state_t r;
	mstu_state_t next_r;

	// radix-2 booth over one 8-bit slice of the multiplier
	function automatic logic [31:0] booth_slice(input logic [31:0] a,
		input logic [7:0] b, input logic prev);
		logic [31:0] sum;
		logic lower;
		sum = 32'h0000_0000;
		lower = prev;
		for (int i = 0; i < mstu_pkg::BOOTH_BITS; i++) begin
			if (b[i] && !lower) begin
				sum = sum - (a << i);
			end else if (!b[i] && lower) begin
				sum = sum + (a << i);
			end
			lower = b[i];
		end
		return sum;
	endfunction

	// iterations needed for a multiplier value
	function automatic logic [2:0] iter_count(input logic [31:0] b, input logic early);
		logic [2:0] m;
		m = mstu_pkg::MAX_ITER;
		if (early) begin
			if (&b[31:8] || ~|b[31:8]) begin
				m = 3'h1; // RQ19
			end else if (&b[31:16] || ~|b[31:16]) begin
				m = 3'h2;
			end else if (&b[31:24] || ~|b[31:24]) begin
				m = 3'h3;
			end
		end
		return m;
	endfunction

	function automatic logic [31:0] reg_read(input mstu_state_t s, input logic [3:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		unique case (a)
			mstu_pkg::ADDR_CUR_STATUS: d = s.cur;
			mstu_pkg::ADDR_SAV_STATUS: d = s.sav;
			mstu_pkg::ADDR_MUL_INFO: d = {27'h000_0000, s.fsm == mstu_pkg::MSTU_IDLE,
				1'b0, s.last_m};
			mstu_pkg::ADDR_CONTROL: d = s.ctl;
			default: d = 32'h0000_0000;
		endcase
		return d;
	endfunction

	logic is_mul;
	logic is_sread;
	logic is_swrite;
	logic privileged;
	logic [31:0] write_src;
	logic [31:0] imm_val;
	logic [31:0] status_new;
	logic [31:0] step_sum;
	logic [31:0] result;
	logic [31:0] last_sum;
	logic mul_done;

	always_comb begin
		// RQ18
		is_mul = issue.instr[27:22] == 6'h00 && issue.instr[7:4] == mstu_pkg::MUL_PATTERN;
		is_sread = issue.instr[27:23] == 5'h02 && issue.instr[21:16] == 6'h0f;
		is_swrite = issue.instr[27:26] == 2'h0 && issue.instr[24:23] == 2'h2
			&& issue.instr[21:20] == 2'h2 && issue.instr[15:12] == 4'hf
			&& (issue.instr[mstu_pkg::BIT_IMM] || issue.instr[11:4] == 8'h00);
		privileged = r.cur[4:0] != mstu_pkg::MODE_USER;
		imm_val = {24'h00_0000, issue.instr[7:0]};
		imm_val = (imm_val >> {issue.instr[11:8], 1'b0})
			| (imm_val << (6'h20 - {1'b0, issue.instr[11:8], 1'b0})); // RQ3
		write_src = (issue.instr[mstu_pkg::BIT_IMM] && !issue.instr[16]) ? imm_val
			: issue.first_val;
		step_sum = r.acc + booth_slice(r.mcand, r.mplier[7:0], r.prev); // RQ8
		// skipped upper bits are uniform: only their first edge adds a term
		last_sum = step_sum;
		if (r.mplier[7] && !r.mplier[8]) begin
			last_sum = step_sum + (r.mcand << mstu_pkg::BOOTH_BITS); // RQ19
		end else if (!r.mplier[7] && r.mplier[8]) begin
			last_sum = step_sum - (r.mcand << mstu_pkg::BOOTH_BITS);
		end
		result = (r.fsm == mstu_pkg::MSTU_ACC) ? r.acc + r.addend : last_sum; // RQ10
	end

	always_comb begin
		next_r = r;
		next_r.wb.valid = 1'b0;
		next_r.retire = 1'b0;
		status_new = 32'h0000_0000;
		mul_done = 1'b0;

		// ahb-lite: zero wait, always okay
		next_r.hreadyout = 1'b1;
		if (r.ahb_wr && r.ahb_addr == mstu_pkg::ADDR_CONTROL) begin
			next_r.ctl = {31'h0000_0000, hwdata[mstu_pkg::CTL_EARLY_TERM_BIT]};
		end
		next_r.ahb_wr = 1'b0;
		if (hsel && hready && htrans == mstu_pkg::HTRANS_NONSEQ) begin
			next_r.ahb_wr = hwrite;
			next_r.ahb_addr = {haddr[3:2], 2'b00};
			next_r.hrdata = reg_read(r, {haddr[3:2], 2'b00});
		end

		unique case (r.fsm)
			mstu_pkg::MSTU_IDLE: begin
				if (issue.valid && r.ready) begin
					next_r.retire = 1'b1; // RQ1
					if (!issue.cond_pass) begin
						next_r.retire = 1'b1; // RQ7
					end else if (is_mul) begin
						next_r.retire = 1'b0;
						next_r.ready = 1'b0;
						next_r.fsm = mstu_pkg::MSTU_ITER;
						next_r.acc = 32'h0000_0000;
						next_r.mcand = issue.first_val;
						next_r.mplier = issue.second_val;
						next_r.prev = 1'b0;
						next_r.iter_left = iter_count(issue.second_val,
							r.ctl[mstu_pkg::CTL_EARLY_TERM_BIT]); // RQ19
						next_r.last_m = next_r.iter_left;
						next_r.addend = issue.addend_val; // RQ13
						next_r.accum = issue.instr[mstu_pkg::BIT_ACCUM];
						next_r.setf = issue.instr[mstu_pkg::BIT_SETF];
						next_r.dest = issue.instr[19:16];
					end else if (is_sread) begin
						next_r.wb.valid = 1'b1;
						next_r.wb.dest = issue.instr[15:12];
						next_r.wb.data = issue.instr[mstu_pkg::BIT_SAVED] ? r.sav : r.cur; // RQ6
					end else if (is_swrite) begin
						status_new = issue.instr[mstu_pkg::BIT_SAVED] ? r.sav : r.cur;
						if (!issue.instr[16] || !privileged) begin
							status_new[31:28] = write_src[31:28]; // RQ2 RQ4
						end else begin
							status_new = write_src; // RQ5
						end
						if (!issue.instr[mstu_pkg::BIT_SAVED]) begin
							next_r.cur = status_new;
						end else if (privileged) begin
							next_r.sav = status_new;
						end
					end
				end
			end
			mstu_pkg::MSTU_ITER: begin
				next_r.acc = step_sum;
				next_r.mcand = r.mcand << mstu_pkg::BOOTH_BITS;
				next_r.prev = r.mplier[7];
				next_r.mplier = {8'h00, r.mplier[31:8]};
				next_r.iter_left = r.iter_left - 3'h1;
				if (r.iter_left == 3'h1) begin
					next_r.acc = last_sum;
					next_r.fsm = mstu_pkg::MSTU_ACC;
					mul_done = !r.accum; // RQ16
				end
			end
			mstu_pkg::MSTU_ACC: begin
				mul_done = 1'b1; // RQ10 RQ16
			end
			default: begin
				next_r.fsm = mstu_pkg::MSTU_IDLE;
				next_r.ready = 1'b1;
			end
		endcase
		// last iteration or accumulate step writes back and frees the unit
		if (mul_done) begin
			next_r.fsm = mstu_pkg::MSTU_IDLE;
			next_r.ready = 1'b1;
			next_r.retire = 1'b1;
			next_r.wb.valid = 1'b1;
			next_r.wb.dest = r.dest;
			next_r.wb.data = result; // RQ9 RQ11
			if (r.setf) begin
				next_r.cur[mstu_pkg::FLAG_N] = result[31]; // RQ14
				next_r.cur[mstu_pkg::FLAG_Z] = result == 32'h0000_0000;
				next_r.cur[mstu_pkg::FLAG_C] = 1'b0; // RQ15
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
			r.fsm <= mstu_pkg::MSTU_IDLE;
			r.ready <= 1'b1;
			r.cur <= mstu_pkg::CUR_STATUS_RESET;
			r.sav <= mstu_pkg::SAV_STATUS_RESET;
			r.ctl <= mstu_pkg::CTL_RESET;
			r.hreadyout <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	always_comb begin
		hrdata = r.hrdata;
		hreadyout = r.hreadyout;
		hresp = 1'b0;
		issue_ready = r.ready;
		wb = r.wb;
		retire = r.retire;
		current_status_word = r.cur;
		saved_status_word = r.sav;
	end

endmodule

// ---- mstu_pkg.sv ----
/*
 * mstu_pkg: constants, encodings and carrier types of the multiply and
 * status transfer unit.
 * assumes: used by mstu_top, mstu_checker, mstu_regfile and mstu_tb; every use is written mstu_pkg::name.
 */
package mstu_pkg;

	// register map, byte addresses of aligned words
	localparam logic [3:0] ADDR_CUR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_SAV_STATUS = 4'h4;
	localparam logic [3:0] ADDR_MUL_INFO = 4'h8;
	localparam logic [3:0] ADDR_CONTROL = 4'hc;

	// control register
	localparam int CTL_EARLY_TERM_BIT = 0;
	localparam logic [31:0] CTL_RESET = 32'h0000_0001;

	// status word layout and reset
	localparam int FLAG_N = 31;
	localparam int FLAG_Z = 30;
	localparam int FLAG_C = 29;
	localparam int FLAG_V = 28;
	localparam logic [4:0] MODE_USER = 5'h10;
	localparam logic [31:0] CUR_STATUS_RESET = 32'h0000_00d3;
	localparam logic [31:0] SAV_STATUS_RESET = 32'h0000_0000;

	// instruction fields
	localparam logic [3:0] MUL_PATTERN = 4'h9;
	localparam int BIT_ACCUM = 21;
	localparam int BIT_SETF = 20;
	localparam int BIT_SAVED = 22;
	localparam int BIT_IMM = 25;

	// multiplier array
	localparam int BOOTH_BITS = 8;
	localparam logic [2:0] MAX_ITER = 3'h4;

	// ahb
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [3:0] {
		MSTU_IDLE = 4'b0001,
		MSTU_ITER = 4'b0010,
		MSTU_ACC = 4'b0100,
		MSTU_DONE = 4'b1000
	} mstu_fsm_t;

	typedef struct packed {
		logic valid;
		logic cond_pass;
		logic [31:0] instr;
		logic [31:0] first_val;
		logic [31:0] second_val;
		logic [31:0] addend_val;
	} mstu_issue_t;

	typedef struct packed {
		logic valid;
		logic [3:0] dest;
		logic [31:0] data;
	} mstu_wb_t;

endpackage

// ---- mstu_checker.sv ----
/* mstu_checker: assertions on issue, write back and status words.
 * assumes: bound into mstu_top, one hclk domain. */
`timescale 1ns/1ps
module mstu_checker (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// issue and results
	input wire mstu_pkg::mstu_issue_t issue,
	input wire logic issue_ready,
	input wire mstu_pkg::mstu_wb_t wb,
	input wire logic retire,
	input wire logic [31:0] current_status_word,
	input wire logic [31:0] saved_status_word
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [31:0] i;
	logic tk, rd, wh, fl, mu, ms, usr;
	logic mp;
	logic [31:0] em;
	assign i = issue.instr;
	assign tk = issue.valid && issue_ready && issue.cond_pass;
	assign rd = i[27:23] == 5'h02 && i[21:16] == 6'h0f;
	assign wh = i[27:23] == 5'h02 && i[21:16] == 6'h29 && !i[22];
	assign fl = i[27:25] == 3'h0 && i[24:23] == 2'h2 && i[21:16] == 6'h28 && !i[22];
	assign mu = i[27:22] == 6'h00 && i[7:4] == 4'h9;
	assign usr = current_status_word[4:0] == mstu_pkg::MODE_USER;
	// multiply in flight, its flag update and its expected result
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mp <= 1'h0;
			ms <= 1'h0;
			em <= 32'h0000_0000;
		end else if (tk && mu) begin
			mp <= 1'h1;
			ms <= i[20];
			em <= issue.first_val * issue.second_val
				+ (i[21] ? issue.addend_val : 32'h0000_0000);
		end else if (retire) begin
			mp <= 1'h0;
			ms <= 1'h0;
		end
	end
	property p_st1; tk && (rd || wh || fl) |=> retire; endproperty
	a_st1: assert property (p_st1) else $error("status op late");
	property p_cf; issue.valid && issue_ready && !issue.cond_pass |=> retire && !wb.valid
		&& $stable(current_status_word) && $stable(saved_status_word); endproperty
	a_cf: assert property (p_cf) else $error("failed condition had effect");
	property p_rd; tk && rd |=> wb.valid && wb.data == ($past(i[22]) ?
		$past(saved_status_word) : $past(current_status_word)); endproperty
	a_rd: assert property (p_rd) else $error("status read wrong");
	property p_fl; tk && (fl || wh && usr) |=> current_status_word ==
		{$past(issue.first_val[31:28]), $past(current_status_word[27:0])}; endproperty
	a_fl: assert property (p_fl) else $error("flags write wrong");
	property p_prv; tk && wh && !usr |=> current_status_word == $past(issue.first_val); endproperty
	a_prv: assert property (p_prv) else $error("whole write wrong");
	property p_len; tk && mu |=> !issue_ready ##[1:5] retire; endproperty
	a_len: assert property (p_len) else $error("multiply length wrong");
	property p_nz; retire && ms |-> current_status_word[31] == wb.data[31]
		&& current_status_word[30] == (wb.data == 32'h0000_0000); endproperty
	a_nz: assert property (p_nz) else $error("n or z wrong");
	property p_v; retire && ms |-> current_status_word[28] == $past(current_status_word[28]);
	endproperty
	a_v: assert property (p_v) else $error("overflow changed");
	property p_mul; retire && mp |-> wb.valid && wb.data == em; endproperty
	a_mul: assert property (p_mul) else $error("multiply result wrong");
	c_mla: cover property (tk && mu && i[21]);
	c_usr: cover property (tk && wh && usr);
	c_cf: cover property (issue.valid && issue_ready && !issue.cond_pass);
endmodule
bind mstu_top mstu_checker mstu_checker_inst (.hclk(hclk), .hresetn(hresetn), .issue(issue),
	.issue_ready(issue_ready), .wb(wb), .retire(retire),
	.current_status_word(current_status_word), .saved_status_word(saved_status_word));

// ---- mstu_regfile.sv ----
/* mstu_regfile: decoder and register file model feeding the unit.
 * assumes: bench drives valid, condition and instruction at hclk edges. */
`timescale 1ns/1ps
module mstu_regfile (
	// clock
	input wire logic hclk,
	// request from bench
	input wire logic v,
	input wire logic cp,
	input wire logic [31:0] ins,
	// unit side
	input wire mstu_pkg::mstu_wb_t wb,
	output mstu_pkg::mstu_issue_t issue
);
	logic [31:0] rf [16];
	// operand fields read out
	assign issue = {v, cp, ins, rf[ins[3:0]], rf[ins[11:8]], rf[ins[15:12]]};
	always @(posedge hclk) begin
		if (wb.valid) rf[wb.dest] <= wb.data;
	end
endmodule

// ---- mstu_tb.sv ----
/* mstu_tb: status transfer and multiply tests through issue and ahb.
 * assumes: mstu_top, mstu_regfile, checker bound. */
`timescale 1ns/1ps
module mstu_tb;
	logic hclk = 0, hresetn = 0, v = 0, cp = 1, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, ins = 0, hrdata, csw, ssw, q;
	logic [1:0] htrans = 0;
	logic hreadyout, hresp, issue_ready, retire;
	mstu_pkg::mstu_issue_t issue;
	mstu_pkg::mstu_wb_t wb;
	int fail_count = 0, checks = 0, n1, n2, n3;
	initial forever #4 hclk = ~hclk;
	mstu_top mstu_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .issue(issue),
		.issue_ready(issue_ready), .wb(wb), .retire(retire), .current_status_word(csw),
		.saved_status_word(ssw));
	mstu_regfile mstu_regfile_inst (.hclk(hclk), .v(v), .cp(cp), .ins(ins), .wb(wb),
		.issue(issue));
	task chk(input string s, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		@(posedge hclk); htrans <= 2'h2; haddr <= a; hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0; hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		r = hrdata;
	endtask
	task op(input logic [31:0] i, input logic c, output int n);
		@(posedge hclk); v <= 1; ins <= i; cp <= c;
		do @(posedge hclk); while (issue_ready !== 1'h1);
		v <= 0; n = 0;
		do begin @(posedge hclk); n++; end while (retire !== 1'h1 && n < 20);
		#1;
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin #40000; fail_count++; report_and_stop; end
	initial begin
		// operands; addend field kept zero in plain multiplies, pc never used
		for (int k = 0; k < 16; k++) mstu_regfile_inst.rf[k] = 0;
		mstu_regfile_inst.rf[0] = 32'h0000_0077;
		mstu_regfile_inst.rf[1] = 32'h1234_5678;
		mstu_regfile_inst.rf[2] = 32'h5fff_ffff;
		mstu_regfile_inst.rf[3] = 32'h0000_0010;
		mstu_regfile_inst.rf[4] = 32'hf000_00d3;
		mstu_regfile_inst.rf[7] = 32'hffff_fff6;
		mstu_regfile_inst.rf[8] = 32'h0000_0014;
		mstu_regfile_inst.rf[10] = 32'h1234_5678;
		mstu_regfile_inst.rf[14] = 32'h0000_0080;
		repeat (6) @(posedge hclk);
		hresetn <= 1;
		bus(0, 32'h0000_0000, 0, q); chk("cur", 32'h0000_00d3, q);
		bus(1, 32'h0000_0000, 32'hffff_ffff, q);
		bus(0, 32'h0000_0010, 0, q); chk("alias", 32'h0000_00d3, q);
		bus(0, 32'h0000_000c, 0, q); chk("ctl", 32'h0000_0001, q);
		$display("test bus done");
		op(32'he328_f20a, 1, n1); chk("imm", 32'ha000_00d3, csw);
		chk("t_imm", 1, 32'(n1));
		op(32'he10f_5000, 1, n1); chk("rd", 32'ha000_00d3, mstu_regfile_inst.rf[5]);
		chk("t_rd", 1, 32'(n1));
		op(32'he169_f001, 1, n1); chk("sav", 32'h1234_5678, ssw);
		op(32'he128_f002, 1, n1); chk("flg", 32'h5000_00d3, csw);
		op(32'he14f_6000, 1, n1); chk("rd_s", 32'h1234_5678, mstu_regfile_inst.rf[6]);
		op(32'he129_f003, 1, n1); chk("priv", 32'h0000_0010, csw);
		op(32'he129_f004, 1, n1); chk("user", 32'hf000_0010, csw);
		$display("test status done");
		op(32'he019_0897, 0, n1); chk("cf", 32'h0000_0000, mstu_regfile_inst.rf[9]);
		op(32'he019_0897, 1, n1); chk("mul", 32'hffff_ff38, mstu_regfile_inst.rf[9]);
		chk("nzv", 32'h0000_0005, {29'h0, csw[31:30], csw[28]});
		chk("t_mul", 32'h0000_0002, 32'(n1));
		bus(0, 32'h0000_0008, 0, q); chk("m1", 32'h0000_0001, {29'h0, q[2:0]});
		op(32'he028_8897, 1, n2); chk("mla", 32'hffff_ff4c, mstu_regfile_inst.rf[8]);
		chk("t_mla", 32'(n1 + 1), 32'(n2));
		op(32'he00b_0a97, 1, n3);
		chk("big", 32'hffff_fff6 * 32'h1234_5678, mstu_regfile_inst.rf[11]);
		chk("t_m4", 32'(n1 + 3), 32'(n3));
		op(32'he01d_0c97, 1, n2); chk("zero", 32'h5000_0010, csw);
		op(32'he00d_0e90, 1, n2); chk("edge", 32'h0000_3b80, mstu_regfile_inst.rf[13]);
		chk("t_edge", 32'h0000_0002, 32'(n2));
		bus(1, 32'h0000_000c, 0, q);
		op(32'he019_0897, 1, n2); chk("no_et", 32'(n3), 32'(n2));
		$display("test multiply done");
		report_and_stop;
	end
endmodule
